// File: src/setctx_pkg.sv
// Shared constants for the set-context leaf execution block
package setctx_pkg;

  // ----------------------------------------
  // Leaf selection and capability
  // ----------------------------------------
  localparam logic [31:0] LEAF_SET_CONTEXT = 32'h0000_0002;
  localparam int          CAP_BIT_POS      = 5;

  // ----------------------------------------
  // Widths and alignment
  // ----------------------------------------
  localparam int ADDR_W       = 64;
  localparam int DATA_W       = 64;
  localparam int PAGE_ALIGN_B = 12;   // 4 KByte boundary
  localparam int VAL_ALIGN_B  = 3;    // 8 Byte boundary

  // ----------------------------------------
  // Page types, result codes, fault kinds
  // ----------------------------------------
  localparam logic [7:0]  CONTROL_PAGE_TYPE   = 8'h00;
  localparam logic [63:0] RESULT_OK           = 64'h0;
  localparam logic [63:0] PAGE_CONFLICT_ERROR = 64'h0000_0000_0000_0009;
  localparam logic [31:0] PF_CODE_PROTECT     = 32'h0000_8000;
  localparam logic [31:0] GP_CODE_ZERO        = 32'h0;

  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_GP   = 2'h1;
  localparam logic [1:0] FAULT_PF   = 2'h2;
  localparam logic [1:0] FAULT_UD   = 2'h3;

  // Reset value of the temporary context register tmp_context_r
  localparam logic [63:0] CONTEXT_RESET = 64'h0;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_CHECK  = 7'h02,
    ST_RDREQ  = 7'h04,
    ST_RDWAIT = 7'h08,
    ST_MAP    = 7'h10,
    ST_WRITE  = 7'h20,
    ST_DONE   = 7'h40
  } state_t;

endpackage

// File: src/context_store.sv
// Small memory holding the context field of each control-structure page
`timescale 1ns/1ps
`default_nettype none
module context_store #(
  parameter int ENTRIES = 16,
  parameter int IDX_W   = 4
) (
  input  wire logic                      clk,
  input  wire logic                      ce,
  input  wire logic                      we,
  input  wire logic [IDX_W-1:0]          waddr,
  input  wire logic [setctx_pkg::DATA_W-1:0] wdata,
  input  wire logic [IDX_W-1:0]          raddr,
  output logic      [setctx_pkg::DATA_W-1:0] rdata
);
  import setctx_pkg::*;

  logic [DATA_W-1:0] mem [ENTRIES];

  // Write port and registered read port
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// File: src/set_context_leaf.sv
// Execution logic of the hypervisor set-context leaf
// ----------------------------------------
// How it works
// RQ1: Runs when selector is 02H, capability bit 5
// RQ2: Operands are data-segment offsets, override ignored
// RQ3: Page pointer misaligned to 4K gives GP(0)
// RQ4: Page outside page cache gives protect page fault
// RQ5: Value pointer misaligned to 8 gives GP(0)
// RQ6: Read 64-bit value before map entry checks
// RQ7: Invalid map entry gives protect page fault
// RQ8: Wrong page type gives protect page fault
// RQ9: Success stores value, result zero, zero flag clear
// RQ10: Page conflict returns error and sets zero flag
// RQ11: Every completion without a fault clears carry parity adjust overflow sign
// RQ12: Concurrent with accept, add and tracking leaves
// RQ13: 32-bit limit or unusable segment gives GP(0)
// RQ14: 64-bit non-canonical gives GP(0), page faults pass
// RQ15: Create and load set field to page address; an init_we write in the ST_WRITE cycle is lost
// RQ16: Unavailable outside protected, in SYSTEM_MANAGEMENT_MODE, VIRTUAL_8086_MODE
// RQ17: Faults leave field, result and flags unchanged
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module set_context_leaf
  import setctx_pkg::*;
#(
  parameter int ENTRIES = 16,
  parameter int IDX_W   = 4
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     ce,
  // Issue
  input  wire logic                     issue,
  input  wire logic [31:0]              leaf_selector,
  input  wire logic [setctx_pkg::ADDR_W-1:0] page_pointer_reg,
  input  wire logic [setctx_pkg::ADDR_W-1:0] value_pointer_reg,
  input  wire logic [31:0]              capability_word,
  // Processor mode
  input  wire logic                     mode_64,
  input  wire logic                     protected_mode,
  input  wire logic                     system_management_mode,
  input  wire logic                     virtual_8086_mode,
  input  wire logic                     paging_enable_bit,
  input  wire logic                     data_segment_usable,
  input  wire logic [31:0]              data_segment_base,
  input  wire logic [31:0]              data_segment_limit,
  // Page cache lookup (same clock, combinational answer)
  input  wire logic                     page_in_cache,
  input  wire logic [IDX_W-1:0]         page_index,
  input  wire logic                     map_valid,
  input  wire logic [7:0]               map_page_type,
  input  wire logic                     page_busy,
  // Memory read of the new value
  output logic                          mem_rd_req,
  output logic [setctx_pkg::ADDR_W-1:0] mem_rd_addr,
  input  wire logic                     mem_rd_ack,
  input  wire logic                     mem_rd_fault,
  input  wire logic [setctx_pkg::DATA_W-1:0] mem_rd_data,
  // Context initialise from create and load leaves
  input  wire logic                     init_we,
  input  wire logic [IDX_W-1:0]         init_index,
  input  wire logic [setctx_pkg::ADDR_W-1:0] init_page_addr,
  // Context readout
  input  wire logic [IDX_W-1:0]         ctx_rd_index,
  output logic [setctx_pkg::DATA_W-1:0] ctx_rd_data,
  // Results
  output logic                          done,
  output logic                          busy,
  output logic [1:0]                    fault_kind,
  output logic [31:0]                   fault_code,
  output logic [setctx_pkg::ADDR_W-1:0] fault_addr,
  output logic [63:0]                   leaf_result_reg,
  output logic                          zero_flag,
  output logic                          carry_flag,
  output logic                          parity_flag,
  output logic                          adjust_flag,
  output logic                          overflow_flag,
  output logic                          sign_flag
);

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  state_t             state_r, state_nxt;
  logic [ADDR_W-1:0]  page_lin_r;
  logic [ADDR_W-1:0]  val_lin_r;
  logic [DATA_W-1:0]  tmp_context_r;
  logic [IDX_W-1:0]   idx_r;
  logic               rd_req_r;
  logic               done_r;
  logic [1:0]         fault_kind_r;
  logic [31:0]        fault_code_r;
  logic [ADDR_W-1:0]  fault_addr_r;
  logic [63:0]        result_r;
  logic               zf_r;
  logic               cf_r, pf_r, af_r, of_r, sf_r;

  // ----------------------------------------
  // Address formation and checks
  // ----------------------------------------
  // Selector and capability enable the leaf
  wire leaf_sel = issue && (leaf_selector == LEAF_SET_CONTEXT)
                  && capability_word[CAP_BIT_POS];                    // [RQ1]
  // Legal processor mode for the leaf family
  wire mode_ok  = protected_mode && !system_management_mode
                  && !virtual_8086_mode && paging_enable_bit;         // [RQ16]

  // Data segment only, no override input exists
  wire [ADDR_W-1:0] page_lin   = mode_64 ? page_pointer_reg
    : {32'h0, page_pointer_reg[31:0] + data_segment_base};            // [RQ2]
  wire [ADDR_W-1:0] val_lin    = mode_64 ? value_pointer_reg
    : {32'h0, value_pointer_reg[31:0] + data_segment_base};           // [RQ2]

  // 32-bit limit and usability checks
  wire seg_fail32 = !mode_64 && (!data_segment_usable
                    || (page_pointer_reg[31:0] > data_segment_limit)
                    || (value_pointer_reg[31:0] > data_segment_limit)); // [RQ13]
  // 64-bit canonical check on 48-bit linear space
  wire canon_p = (page_pointer_reg[63:47] == {17{page_pointer_reg[47]}});
  wire canon_v = (value_pointer_reg[63:47] == {17{value_pointer_reg[47]}});
  wire seg_fail64 = mode_64 && !(canon_p && canon_v);                 // [RQ14]
  wire seg_fail   = seg_fail32 || seg_fail64;

  wire page_misal = |page_lin_r[PAGE_ALIGN_B-1:0];                    // [RQ3]
  wire val_misal  = |val_lin_r[VAL_ALIGN_B-1:0];                      // [RQ5]

  // Context store port mux: init leaves or this leaf's final write
  wire              st_write = (state_r == ST_WRITE);
  wire              st_we    = ce && (st_write || init_we);
  wire [IDX_W-1:0]  st_waddr = st_write ? idx_r : init_index;
  wire [DATA_W-1:0] st_wdata = st_write ? tmp_context_r : init_page_addr; // [RQ15]

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:   if (leaf_sel) state_nxt = ST_CHECK;
      ST_CHECK:  state_nxt = ST_RDREQ;
      // An acknowledge in the request cycle itself is not lost
      ST_RDREQ,
      ST_RDWAIT: state_nxt = mem_rd_ack ? ST_MAP : ST_RDWAIT;
      ST_MAP:    state_nxt = ST_WRITE;
      ST_WRITE:  state_nxt = ST_DONE;
      ST_DONE:   state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Sequencer with fault exits
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r       <= ST_IDLE;
      page_lin_r    <= '0;
      val_lin_r     <= '0;
      tmp_context_r <= CONTEXT_RESET;
      idx_r         <= '0;
      rd_req_r      <= 1'b0;
      done_r        <= 1'b0;
      fault_kind_r  <= FAULT_NONE;
      fault_code_r  <= GP_CODE_ZERO;
      fault_addr_r  <= '0;
      result_r      <= RESULT_OK;
      zf_r          <= 1'b0;
      {cf_r, pf_r, af_r, of_r, sf_r} <= 5'h00;
    end else if (ce) begin
      state_r  <= state_nxt;
      done_r   <= 1'b0;
      rd_req_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (leaf_sel) begin
            page_lin_r   <= page_lin;
            val_lin_r    <= val_lin;
            fault_kind_r <= FAULT_NONE;
            if (!mode_ok) begin
              fault_kind_r <= FAULT_UD;                               // [RQ16]
              done_r       <= 1'b1;
              state_r      <= ST_IDLE;
            end else if (seg_fail) begin
              fault_kind_r <= FAULT_GP;                               // [RQ13] [RQ14]
              fault_code_r <= GP_CODE_ZERO;
              done_r       <= 1'b1;
              state_r      <= ST_IDLE;
            end
          end
        end
        ST_CHECK: begin
          // Ordered: page alignment, residency, value alignment
          if (page_misal) begin
            fault_kind_r <= FAULT_GP;                                 // [RQ3]
            fault_code_r <= GP_CODE_ZERO;
            done_r       <= 1'b1;
            state_r      <= ST_IDLE;
          end else if (!page_in_cache) begin
            fault_kind_r <= FAULT_PF;                                 // [RQ4]
            fault_code_r <= PF_CODE_PROTECT;
            fault_addr_r <= page_lin_r;
            done_r       <= 1'b1;
            state_r      <= ST_IDLE;
          end else if (val_misal) begin
            fault_kind_r <= FAULT_GP;                                 // [RQ5]
            fault_code_r <= GP_CODE_ZERO;
            done_r       <= 1'b1;
            state_r      <= ST_IDLE;
          end else begin
            idx_r    <= page_index;
            rd_req_r <= 1'b1;                                         // [RQ6]
          end
        end
        ST_RDREQ,
        ST_RDWAIT: begin
          rd_req_r <= !mem_rd_ack;
          if (mem_rd_ack) begin
            if (mem_rd_fault) begin
              fault_kind_r <= FAULT_PF;                               // [RQ14]
              fault_code_r <= GP_CODE_ZERO;
              fault_addr_r <= val_lin_r;
              done_r       <= 1'b1;
              state_r      <= ST_IDLE;
            end else begin
              tmp_context_r <= mem_rd_data;                           // [RQ6]
            end
          end
        end
        ST_MAP: begin
          if (!map_valid || (map_page_type != CONTROL_PAGE_TYPE)) begin
            fault_kind_r <= FAULT_PF;                                 // [RQ7] [RQ8]
            fault_code_r <= PF_CODE_PROTECT;
            fault_addr_r <= page_lin_r;
            done_r       <= 1'b1;
            state_r      <= ST_IDLE;                                  // [RQ17]
          end else if (page_busy) begin
            // Only a modifying leaf conflicts; others run alongside
            result_r <= PAGE_CONFLICT_ERROR;                          // [RQ10] [RQ12]
            zf_r     <= 1'b1;
            {cf_r, pf_r, af_r, of_r, sf_r} <= 5'h00;                  // [RQ11]
            done_r   <= 1'b1;
            state_r  <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          result_r <= RESULT_OK;                                      // [RQ9]
          zf_r     <= 1'b0;
          {cf_r, pf_r, af_r, of_r, sf_r} <= 5'h00;                    // [RQ11]
          done_r   <= 1'b1;
        end
        ST_DONE: begin
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Context field storage
  // ----------------------------------------
  context_store #(
    .ENTRIES (ENTRIES),
    .IDX_W   (IDX_W)
  ) u_store (
    .clk   (clk),
    .ce    (ce),
    .we    (st_we),                                                   // [RQ9]
    .waddr (st_waddr),
    .wdata (st_wdata),
    .raddr (ctx_rd_index),
    .rdata (ctx_rd_data)
  );

  // Outputs straight from flops, except busy which is decoded from state_r
  assign mem_rd_req    = rd_req_r;
  assign mem_rd_addr   = val_lin_r;
  assign done          = done_r;
  assign busy          = (state_r != ST_IDLE);
  assign fault_kind    = fault_kind_r;
  assign fault_code    = fault_code_r;
  assign fault_addr    = fault_addr_r;
  assign leaf_result_reg = result_r;
  assign zero_flag     = zf_r;
  assign carry_flag    = cf_r;
  assign parity_flag   = pf_r;
  assign adjust_flag   = af_r;
  assign overflow_flag = of_r;
  assign sign_flag     = sf_r;

endmodule
`default_nettype wire

// File: verif/set_context_leaf_checker.sv
// Assertion checker for the set-context leaf block
`timescale 1ns/1ps
`default_nettype none
module set_context_leaf_checker
  import setctx_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        issue,
  input wire logic [31:0] leaf_selector,
  input wire logic [31:0] capability_word,
  input wire logic        protected_mode,
  input wire logic        mem_rd_req,
  input wire logic [63:0] mem_rd_addr,
  input wire logic        mem_rd_ack,
  input wire logic        done,
  input wire logic        busy,
  input wire logic [1:0]  fault_kind,
  input wire logic [31:0] fault_code,
  input wire logic [63:0] leaf_result_reg,
  input wire logic        zero_flag,
  input wire logic        carry_flag,
  input wire logic        parity_flag,
  input wire logic        adjust_flag,
  input wire logic        overflow_flag,
  input wire logic        sign_flag
);
  // ----------------------------------------
  // Helpers and sequences
  // ----------------------------------------
  logic flags_zero;
  assign flags_zero = !(carry_flag | parity_flag | adjust_flag | overflow_flag | sign_flag);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_taken;
    !busy && issue && leaf_selector == LEAF_SET_CONTEXT && capability_word[CAP_BIT_POS];
  endsequence
  sequence s_rd_ok;
    mem_rd_req && mem_rd_ack;
  endsequence
  sequence s_ok_done;
    done && fault_kind == FAULT_NONE;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_taken_starts: assert property (s_taken |=> busy || done)
    else $error("accepted leaf did not start");
  chk_wrong_leaf: assert property (!busy && issue
    && leaf_selector != LEAF_SET_CONTEXT |=> !busy && !done)
    else $error("wrong selector started a leaf");
  chk_mode_refuse: assert property (s_taken ##0 !protected_mode
    |-> ##[1:2] done && fault_kind == FAULT_UD) else $error("illegal mode not refused");
  chk_gp_code: assert property (done && fault_kind == FAULT_GP |-> fault_code == GP_CODE_ZERO)
    else $error("protection fault code not zero");
  chk_rd_hold: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("read request dropped or moved");
  chk_rd_align: assert property ($rose(mem_rd_req) |-> mem_rd_addr[VAL_ALIGN_B-1:0] == 3'h0)
    else $error("misaligned value read");
  chk_rd_to_done: assert property (s_rd_ok |-> ##[1:4] done)
    else $error("no completion after value read");
  chk_ok_result: assert property (s_ok_done |->
    (leaf_result_reg == RESULT_OK && !zero_flag) ||
    (leaf_result_reg == PAGE_CONFLICT_ERROR && zero_flag))
    else $error("bad result or zero flag");
  chk_flags_clear: assert property (s_ok_done |-> flags_zero)
    else $error("status flags not cleared");
  chk_fault_hold: assert property (done && fault_kind != FAULT_NONE
    |-> $stable(leaf_result_reg) && $stable(zero_flag)) else $error("fault changed result");
endmodule
bind set_context_leaf set_context_leaf_checker i_chk (.clk(clk), .srst(srst), .issue(issue),
  .leaf_selector(leaf_selector), .capability_word(capability_word),
  .protected_mode(protected_mode), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
  .mem_rd_ack(mem_rd_ack), .done(done), .busy(busy), .fault_kind(fault_kind),
  .fault_code(fault_code), .leaf_result_reg(leaf_result_reg), .zero_flag(zero_flag),
  .carry_flag(carry_flag), .parity_flag(parity_flag), .adjust_flag(adjust_flag),
  .overflow_flag(overflow_flag), .sign_flag(sign_flag));
`default_nettype wire

// File: verif/tb_set_context_leaf.sv
// Self-checking testbench for the set-context leaf block
`timescale 1ns/1ps
`default_nettype none
module tb_set_context_leaf;
  import setctx_pkg::*;
  // ----------------------------------------
  // Signals and case table
  // ----------------------------------------
  logic clk, srst, ce, issue, mode_64, protected_mode, system_management_mode;
  logic virtual_8086_mode, paging_enable_bit, data_segment_usable, page_in_cache, map_valid;
  logic page_busy, mem_rd_ack, mem_rd_fault, init_we, mem_rd_req, done, busy, zero_flag;
  logic carry_flag, parity_flag, adjust_flag, overflow_flag, sign_flag, seen;
  logic [31:0] leaf_selector, capability_word, data_segment_base, data_segment_limit, fault_code;
  logic [63:0] page_pointer_reg, value_pointer_reg, mem_rd_addr, mem_rd_data, init_page_addr;
  logic [63:0] ctx_rd_data, fault_addr, leaf_result_reg, exp_res, exp_ctx;
  logic [3:0]  page_index, init_index, ctx_rd_index;
  logic [7:0]  map_page_type;
  logic [1:0]  fault_kind;
  logic        exp_zf;
  int          miscompares, n_tests;
  // Mode: limit small, 64-bit, protected, smm, v86, paging, ds usable
  // Lookup: in cache, map valid, busy page, read fault, reissue, bad type
  typedef struct packed {
    logic [63:0] pg;
    logic [63:0] vp;
    logic [6:0]  md;
    logic [5:0]  lk;
    logic [1:0]  fk;
    logic        zf;
  } row_t;
  row_t rows [17] = '{
    '{64'h3000,64'h2008,7'h33,6'h30,2'h0,1'b0}, '{64'h3004,64'h2008,7'h33,6'h30,2'h1,1'b0},
    '{64'h3000,64'h2008,7'h33,6'h10,2'h2,1'b0}, '{64'h3000,64'h2004,7'h33,6'h30,2'h1,1'b0},
    '{64'h3000,64'h2008,7'h33,6'h20,2'h2,1'b0}, '{64'h3000,64'h2008,7'h33,6'h31,2'h2,1'b0},
    '{64'h3000,64'h2008,7'h33,6'h38,2'h0,1'b1}, '{64'h3000,64'h2008,7'h23,6'h30,2'h3,1'b0},
    '{64'h3000,64'h2008,7'h3b,6'h30,2'h3,1'b0}, '{64'h3000,64'h2008,7'h37,6'h30,2'h3,1'b0},
    '{64'h3000,64'h2008,7'h31,6'h30,2'h3,1'b0}, '{64'h3000,64'h2008,7'h53,6'h30,2'h1,1'b0},
    '{64'h3000,64'h2008,7'h12,6'h30,2'h1,1'b0},
    '{64'h8000_0000_0000,64'h2008,7'h33,6'h30,2'h1,1'b0},
    '{64'h3000,64'h2008,7'h33,6'h34,2'h2,1'b0}, '{64'h3004,64'h2008,7'h33,6'h10,2'h1,1'b0},
    '{64'h3000,64'h2008,7'h13,6'h32,2'h0,1'b0}};

  set_context_leaf i_set_context_leaf (.clk, .srst, .ce, .issue, .leaf_selector, .page_pointer_reg,
    .value_pointer_reg, .capability_word, .mode_64, .protected_mode, .system_management_mode,
    .virtual_8086_mode, .paging_enable_bit, .data_segment_usable, .data_segment_base,
    .data_segment_limit, .page_in_cache, .page_index, .map_valid, .map_page_type, .page_busy,
    .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_fault, .mem_rd_data, .init_we, .init_index,
    .init_page_addr, .ctx_rd_index, .ctx_rd_data, .done, .busy, .fault_kind, .fault_code,
    .fault_addr, .leaf_result_reg, .zero_flag, .carry_flag, .parity_flag, .adjust_flag,
    .overflow_flag, .sign_flag);

  // ----------------------------------------
  // Clock, checks and leaf driver
  // ----------------------------------------
  always #12.5 clk = ~clk;

  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task run(input row_t r, input int i);
    int k;
    logic acked;
    logic [63:0] dat;
    begin
      dat = 64'h5a5a_0000_0000_0000 + 64'(i);
      k = 0;
      acked = 1'b0;
      page_pointer_reg = r.pg;
      value_pointer_reg = r.vp;
      {mode_64, protected_mode, system_management_mode, virtual_8086_mode, paging_enable_bit,
       data_segment_usable} = r.md[5:0];
      data_segment_limit = r.md[6] ? 32'h0000_0fff : 32'hffff_ffff;
      {page_in_cache, map_valid, page_busy} = r.lk[5:3];
      map_page_type = {7'h00, r.lk[0]};
      issue = 1'b1;
      do begin
        @(negedge clk);
        issue = r.lk[1] && k == 3; // Ignored while busy
        if (r.lk[1] && k == 3) value_pointer_reg = 64'h2010;
        mem_rd_ack = 1'b0;
        mem_rd_data = ~dat;
        if (mem_rd_req && !acked && k > 4) begin
          chk("rd_addr", mem_rd_addr, r.vp);
          mem_rd_ack = 1'b1;
          mem_rd_fault = r.lk[2];
          mem_rd_data = dat;
          acked = 1'b1;
        end
        k++;
      end while (!done && k < 40);
      chk("done", 64'(done), 64'h1);
      chk("fault_kind", 64'(fault_kind), 64'(r.fk));
      if (r.fk == FAULT_NONE) begin
        exp_res = r.zf ? PAGE_CONFLICT_ERROR : RESULT_OK;
        exp_zf = r.zf;
        if (!r.zf) exp_ctx = dat;
      end else if (r.fk != FAULT_UD) begin
        chk("fault_code", 64'(fault_code), (r.fk == FAULT_PF && !r.lk[2]) ? 64'h8000 : 64'h0);
      end
      if (r.fk == FAULT_PF && !r.lk[2]) chk("fault_addr", fault_addr, r.pg);
      chk("result", leaf_result_reg, exp_res);
      chk("zero_flag", 64'(zero_flag), 64'(exp_zf));
      chk("flags", 64'({carry_flag, parity_flag, adjust_flag, overflow_flag, sign_flag}), 64'h0);
      repeat (2) @(negedge clk);
      chk("context", ctx_rd_data, exp_ctx);
    end
  endtask

  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  initial begin
    #125000;
    miscompares++;
    close_out();
  end

  initial begin
    {clk, issue, mem_rd_ack, mem_rd_fault, init_we, exp_zf, seen} = '0;
    {srst, ce, data_segment_usable, paging_enable_bit, protected_mode, mode_64} = '1;
    {system_management_mode, virtual_8086_mode, page_in_cache, map_valid, page_busy} = '0;
    leaf_selector = LEAF_SET_CONTEXT;
    capability_word = 32'h0000_0020;
    {data_segment_base, data_segment_limit} = {32'h0, 32'hffff_ffff};
    {page_pointer_reg, value_pointer_reg, mem_rd_data} = '0;
    {page_index, init_index, ctx_rd_index, map_page_type} = {12'h333, 8'h00};
    {init_page_addr, exp_res} = '0;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk("reset", 64'({done, busy, fault_kind, zero_flag}), 64'h0);
    chk("reset_result", leaf_result_reg, 64'h0);
    init_we = 1'b1; // Create or load leaf seeds the field
    init_page_addr = 64'h3000;
    exp_ctx = 64'h3000;
    @(negedge clk);
    init_we = 1'b0;
    repeat (2) @(negedge clk);
    chk("context_init", ctx_rd_data, exp_ctx);
    for (int i = 0; i < 17; i++) run(rows[i], i);
    for (int j = 0; j < 2; j++) begin
      leaf_selector = j ? LEAF_SET_CONTEXT : 32'h3;
      capability_word = j ? 32'h0 : 32'h20;
      issue = 1'b1;
      @(negedge clk);
      issue = 1'b0;
      seen = 1'b0;
      repeat (4) begin
        seen = seen | done | busy;
        @(negedge clk);
      end
      chk("ignored", 64'(seen), 64'h0);
    end
    close_out();
  end
endmodule
`default_nettype wire
